// ==== verilog/ubcs_regs.svh ====
// Purpose: offsets, field positions, codes and timing counts for the bit-rate clock selector
// Assumes: crystal_input_clock is the block clock
// Notes: fixed-rate divisors are crystal cycles per 16x tick at the nominal crystal frequency
`ifndef UBCS_REGS_SVH
`define UBCS_REGS_SVH

`define UBCS_ADDR_W 8
`define UBCS_DATA_W 8
`define UBCS_RX_SRC_OFS 8'h30
`define UBCS_TX_SRC_OFS 8'h31
`define UBCS_STATUS_OFS 8'h32

`define UBCS_SEL_W 6
`define UBCS_SEL_MSB 5
`define UBCS_RSVD_W 2
`define UBCS_SRC_RESET 6'h0B

`define UBCS_CODE_LOW_LAST 6'h0C
`define UBCS_CODE_TIMER0 6'h0D
`define UBCS_CODE_EXT16 6'h0E
`define UBCS_CODE_EXT1 6'h0F
`define UBCS_CODE_HIGH_FIRST 6'h10
`define UBCS_CODE_HIGH_LAST 6'h1C
`define UBCS_CODE_TIMER1 6'h1D
`define UBCS_CODE_PGEN0 6'h1E
`define UBCS_CODE_MIDI 6'h1F
`define UBCS_CODE_PGEN1 6'h3E

`define UBCS_REF_HZ 14745600
`define UBCS_OVERSAMPLE 16
`define UBCS_DIV_W 15
`define UBCS_DIV(b) (`UBCS_REF_HZ / (`UBCS_OVERSAMPLE * (b)))
`define UBCS_DIV_TENTHS(b) (`UBCS_REF_HZ * 10 / (`UBCS_OVERSAMPLE * (b)))
`define UBCS_OS_CNT_W 4
`define UBCS_OS_LAST 4'hF

`define UBCS_ST_RX_RSVD 0
`define UBCS_ST_TX_RSVD 1
`define UBCS_ST_RX_1X 2
`define UBCS_ST_TX_1X 3
`define UBCS_ST_RX_EXT_SEEN 4
`define UBCS_ST_TX_EXT_SEEN 5

`endif

// ==== verilog/ubcs_pkg.sv ====
// Purpose: types shared by the bit-rate clock selector
// Assumes: nothing beyond the regs header
// Notes: source kinds are what a 6-bit select code decodes to
`default_nettype none
package ubcs_pkg;

    typedef enum {
        UBCS_SRC_FIXED,
        UBCS_SRC_TIMER0,
        UBCS_SRC_TIMER1,
        UBCS_SRC_PGEN0,
        UBCS_SRC_PGEN1,
        UBCS_SRC_EXT16,
        UBCS_SRC_EXT1,
        UBCS_SRC_NONE
    } ubcs_src_t;

    typedef struct packed {
        logic timer0_tick;
        logic timer1_tick;
        logic pgen0_tick;
        logic pgen1_tick;
    } ubcs_src_in_t;

    typedef struct packed {
        logic tick16;
        logic bit_tick;
        logic mode_1x;
        logic active;
    } ubcs_clk_out_t;

endpackage
`default_nettype wire

// ==== verilog/ubcs_rate_gen.sv ====
// Purpose: divides the crystal clock to one 16x tick per divisor cycles
// Assumes: divisor of at least one, restart a one-cycle pulse
// Notes: counting crystal cycles makes every fixed rate scale with the crystal
`default_nettype none
`timescale 1ns/1ps
`include "ubcs_regs.svh"
module ubcs_rate_gen
    import ubcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic restart,
    input wire logic [`UBCS_DIV_W-1:0] divisor,
    output logic tick
);
    logic [`UBCS_DIV_W-1:0] cnt_q;

    // reload on restart so a new rate starts with a full period
    always_ff @(posedge clk) begin
        if (rst || restart || !enable) begin
            cnt_q <= '0;
        end else if (cnt_q >= divisor - `UBCS_DIV_W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `UBCS_DIV_W'(1);
        end
    end

    assign tick = enable && !restart && (cnt_q >= divisor - `UBCS_DIV_W'(1));
endmodule // ubcs_rate_gen
`default_nettype wire

// ==== verilog/ubcs_top.sv ====
// Purpose: selects receiver and transmitter bit-rate clocks from a 6-bit code each
// Assumes: clk is the crystal clock; timer and generator ticks are one-cycle pulses at 16x rate
// Notes: external pins are sampled on clk, so they must run well below half its rate
//
// What this block does
// [R1] The receiver source register sits at 0x30 and the transmitter one at 0x31, code in bits 5:0.
// [R2] Bits 7:6 of both source registers are not stored and read back as zero.
// [R3] Fixed rates are counted off the crystal clock, so they follow its frequency in exact ratio.
// [R4] Codes 0x00 to 0x0C pick fixed rates 50 up to 38.4k baud in the listed order.
// [R5] Codes 0x10 to 0x1C pick fixed rates 75 up to 921.6k baud in the listed order.
// [R6] Code 0x0D picks timer zero, 0x1D timer one, 0x1E and 0x3E the two programmable generators, the rest high codes are reserved.
// [R7] For the transmitter, 0x0E and 0x0F take a 16x or 1x clock from the third general-purpose pin.
// [R8] For the receiver, 0x0E and 0x0F take a 16x or 1x clock from the fourth general-purpose pin.
// [R9] Code 0x1F picks the 31.25 kHz MIDI rate, with its small error at the nominal crystal.
// [R10] Receiver and transmitter each follow only their own register.
// [R11] All sources except external 1x are 16x clocks, and the bit tick is every sixteenth of them.
`default_nettype none
`timescale 1ns/1ps
`include "ubcs_regs.svh"
module ubcs_top
    import ubcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`UBCS_ADDR_W-1:0] addr,
    input wire logic [`UBCS_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`UBCS_DATA_W-1:0] rdata,
    input wire ubcs_src_in_t src_in,
    input wire logic gpio_three_in,
    input wire logic gpio_four_in,
    output ubcs_clk_out_t rx_clk,
    output ubcs_clk_out_t tx_clk
);

    // code to source kind
    function automatic ubcs_src_t decode_src(input logic [`UBCS_SEL_MSB:0] code);
        ubcs_src_t s;
        s = UBCS_SRC_NONE; // R6
        if (code <= `UBCS_CODE_LOW_LAST) begin
            s = UBCS_SRC_FIXED; // R4
        end else if (code >= `UBCS_CODE_HIGH_FIRST && code <= `UBCS_CODE_HIGH_LAST) begin
            s = UBCS_SRC_FIXED; // R5
        end else begin
            case (code)
                `UBCS_CODE_TIMER0: s = UBCS_SRC_TIMER0; // R6
                `UBCS_CODE_TIMER1: s = UBCS_SRC_TIMER1; // R6
                `UBCS_CODE_PGEN0: s = UBCS_SRC_PGEN0; // R6
                `UBCS_CODE_PGEN1: s = UBCS_SRC_PGEN1; // R6
                `UBCS_CODE_EXT16: s = UBCS_SRC_EXT16; // R7 R8
                `UBCS_CODE_EXT1: s = UBCS_SRC_EXT1; // R7 R8
                `UBCS_CODE_MIDI: s = UBCS_SRC_FIXED; // R9
                default: s = UBCS_SRC_NONE;
            endcase
        end
        return s;
    endfunction

    // crystal cycles per 16x tick; non-integer ratios truncate
    function automatic logic [`UBCS_DIV_W-1:0] fixed_div(input logic [`UBCS_SEL_MSB:0] code);
        logic [`UBCS_DIV_W-1:0] d;
        d = `UBCS_DIV_W'(1);
        case (code)
            6'h00: d = `UBCS_DIV_W'(`UBCS_DIV(50)); // R4
            6'h01: d = `UBCS_DIV_W'(`UBCS_DIV(110));
            6'h02: d = `UBCS_DIV_W'(`UBCS_DIV_TENTHS(1345));
            6'h03: d = `UBCS_DIV_W'(`UBCS_DIV(200));
            6'h04: d = `UBCS_DIV_W'(`UBCS_DIV(300));
            6'h05: d = `UBCS_DIV_W'(`UBCS_DIV(600));
            6'h06: d = `UBCS_DIV_W'(`UBCS_DIV(1200));
            6'h07: d = `UBCS_DIV_W'(`UBCS_DIV(1050));
            6'h08: d = `UBCS_DIV_W'(`UBCS_DIV(2400));
            6'h09: d = `UBCS_DIV_W'(`UBCS_DIV(4800));
            6'h0A: d = `UBCS_DIV_W'(`UBCS_DIV(7200));
            6'h0B: d = `UBCS_DIV_W'(`UBCS_DIV(9600));
            6'h0C: d = `UBCS_DIV_W'(`UBCS_DIV(38400));
            6'h10: d = `UBCS_DIV_W'(`UBCS_DIV(75)); // R5
            6'h11: d = `UBCS_DIV_W'(`UBCS_DIV(150));
            6'h12: d = `UBCS_DIV_W'(`UBCS_DIV(450));
            6'h13: d = `UBCS_DIV_W'(`UBCS_DIV(1800));
            6'h14: d = `UBCS_DIV_W'(`UBCS_DIV(2000));
            6'h15: d = `UBCS_DIV_W'(`UBCS_DIV(14400));
            6'h16: d = `UBCS_DIV_W'(`UBCS_DIV(19200));
            6'h17: d = `UBCS_DIV_W'(`UBCS_DIV(28800));
            6'h18: d = `UBCS_DIV_W'(`UBCS_DIV(57600));
            6'h19: d = `UBCS_DIV_W'(`UBCS_DIV(115200));
            6'h1A: d = `UBCS_DIV_W'(`UBCS_DIV(230400));
            6'h1B: d = `UBCS_DIV_W'(`UBCS_DIV(460800));
            6'h1C: d = `UBCS_DIV_W'(`UBCS_DIV(921600));
            6'h1F: d = `UBCS_DIV_W'(`UBCS_DIV(31250)); // R9
            default: d = `UBCS_DIV_W'(1);
        endcase
        return d;
    endfunction

    // one 16x or 1x edge from whichever source is chosen
    function automatic logic pick_tick(input ubcs_src_t s, input ubcs_src_in_t i,
                                       input logic gen, input logic ext_edge);
        logic t;
        t = 1'b0;
        case (s)
            UBCS_SRC_FIXED: t = gen; // R3
            UBCS_SRC_TIMER0: t = i.timer0_tick; // R6
            UBCS_SRC_TIMER1: t = i.timer1_tick;
            UBCS_SRC_PGEN0: t = i.pgen0_tick;
            UBCS_SRC_PGEN1: t = i.pgen1_tick;
            UBCS_SRC_EXT16: t = ext_edge;
            UBCS_SRC_EXT1: t = ext_edge;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    logic [`UBCS_SEL_MSB:0] rx_sel_q;
    logic [`UBCS_SEL_MSB:0] tx_sel_q;
    logic rx_restart_q;
    logic tx_restart_q;
    logic rx_wr;
    logic tx_wr;

    logic [`UBCS_DATA_W-1:0] rdata_q;
    logic [`UBCS_DATA_W-1:0] rdata_d;

    ubcs_src_t rx_src;
    ubcs_src_t tx_src;
    logic rx_is_ext1;
    logic tx_is_ext1;

    logic rx_gen_tick;
    logic tx_gen_tick;

    logic gpio_three_q;
    logic gpio_four_q;
    logic rx_ext_edge;
    logic tx_ext_edge;
    logic rx_raw;
    logic tx_raw;
    logic [`UBCS_OS_CNT_W-1:0] rx_os_q;
    logic [`UBCS_OS_CNT_W-1:0] tx_os_q;

    logic rx_tick16_q;
    logic tx_tick16_q;
    logic rx_bit_q;
    logic tx_bit_q;

    logic rx_ext_seen_q;
    logic tx_ext_seen_q;

    assign rx_wr = wr && (addr == `UBCS_RX_SRC_OFS); // R1
    assign tx_wr = wr && (addr == `UBCS_TX_SRC_OFS); // R1

    // reserved bits are never stored
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_sel_q <= `UBCS_SRC_RESET;
        end else if (rx_wr) begin
            rx_sel_q <= wdata[`UBCS_SEL_MSB:0]; // R1 R2 R10
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_sel_q <= `UBCS_SRC_RESET;
        end else if (tx_wr) begin
            tx_sel_q <= wdata[`UBCS_SEL_MSB:0]; // R1 R2 R10
        end
    end

    // any write restarts that side only, so the first tick is a full period
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_restart_q <= 1'b1;
        end else begin
            rx_restart_q <= rx_wr; // R10
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_restart_q <= 1'b1;
        end else begin
            tx_restart_q <= tx_wr; // R10
        end
    end

    assign rx_src = decode_src(rx_sel_q);
    assign tx_src = decode_src(tx_sel_q);
    assign rx_is_ext1 = rx_src == UBCS_SRC_EXT1; // R8
    assign tx_is_ext1 = tx_src == UBCS_SRC_EXT1; // R7

    ubcs_rate_gen u_rx_gen (
        .clk(clk),
        .rst(rst),
        .enable(rx_src == UBCS_SRC_FIXED),
        .restart(rx_restart_q),
        .divisor(fixed_div(rx_sel_q)), // R3 R4 R5 R9
        .tick(rx_gen_tick)
    );

    ubcs_rate_gen u_tx_gen (
        .clk(clk),
        .rst(rst),
        .enable(tx_src == UBCS_SRC_FIXED),
        .restart(tx_restart_q),
        .divisor(fixed_div(tx_sel_q)), // R3 R4 R5 R9
        .tick(tx_gen_tick)
    );

    // pins are synchronous inputs; a rising edge is one clock event
    always_ff @(posedge clk) begin
        if (rst) begin
            gpio_three_q <= 1'b0;
        end else begin
            gpio_three_q <= gpio_three_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            gpio_four_q <= 1'b0;
        end else begin
            gpio_four_q <= gpio_four_in;
        end
    end

    assign tx_ext_edge = gpio_three_in && !gpio_three_q; // R7
    assign rx_ext_edge = gpio_four_in && !gpio_four_q; // R8

    assign rx_raw = !rx_restart_q && pick_tick(rx_src, src_in, rx_gen_tick, rx_ext_edge);
    assign tx_raw = !tx_restart_q && pick_tick(tx_src, src_in, tx_gen_tick, tx_ext_edge);

    // 16x events count to a bit; a 1x edge is a bit by itself
    always_ff @(posedge clk) begin
        if (rst || rx_restart_q) begin
            rx_os_q <= '0;
        end else if (rx_raw && rx_src != UBCS_SRC_EXT1) begin
            rx_os_q <= rx_os_q + `UBCS_OS_CNT_W'(1); // R11
        end
    end

    always_ff @(posedge clk) begin
        if (rst || tx_restart_q) begin
            tx_os_q <= '0;
        end else if (tx_raw && tx_src != UBCS_SRC_EXT1) begin
            tx_os_q <= tx_os_q + `UBCS_OS_CNT_W'(1); // R11
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_tick16_q <= 1'b0;
            rx_bit_q <= 1'b0;
        end else begin
            rx_tick16_q <= rx_raw && rx_src != UBCS_SRC_EXT1; // R11
            rx_bit_q <= rx_raw && (rx_src == UBCS_SRC_EXT1 || rx_os_q == `UBCS_OS_LAST); // R11
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_tick16_q <= 1'b0;
            tx_bit_q <= 1'b0;
        end else begin
            tx_tick16_q <= tx_raw && tx_src != UBCS_SRC_EXT1; // R11
            tx_bit_q <= tx_raw && (tx_src == UBCS_SRC_EXT1 || tx_os_q == `UBCS_OS_LAST); // R11
        end
    end

    // sticky until that side's source is rewritten; the event wins over the clear
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ext_seen_q <= 1'b0;
        end else if (rx_ext_edge && (rx_src == UBCS_SRC_EXT16 || rx_is_ext1)) begin
            rx_ext_seen_q <= 1'b1;
        end else if (rx_wr) begin
            rx_ext_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_ext_seen_q <= 1'b0;
        end else if (tx_ext_edge && (tx_src == UBCS_SRC_EXT16 || tx_is_ext1)) begin
            tx_ext_seen_q <= 1'b1;
        end else if (tx_wr) begin
            tx_ext_seen_q <= 1'b0;
        end
    end

    always_comb begin
        rx_clk = '0;
        rx_clk.tick16 = rx_tick16_q;
        rx_clk.bit_tick = rx_bit_q;
        rx_clk.mode_1x = rx_is_ext1; // R11
        rx_clk.active = rx_src != UBCS_SRC_NONE; // R6
    end

    always_comb begin
        tx_clk = '0;
        tx_clk.tick16 = tx_tick16_q;
        tx_clk.bit_tick = tx_bit_q;
        tx_clk.mode_1x = tx_is_ext1; // R11
        tx_clk.active = tx_src != UBCS_SRC_NONE; // R6
    end

    // read data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        case (addr)
            `UBCS_RX_SRC_OFS: rdata_d = {{`UBCS_RSVD_W{1'b0}}, rx_sel_q}; // R2
            `UBCS_TX_SRC_OFS: rdata_d = {{`UBCS_RSVD_W{1'b0}}, tx_sel_q}; // R2
            `UBCS_STATUS_OFS: begin
                rdata_d[`UBCS_ST_RX_RSVD] = rx_src == UBCS_SRC_NONE;
                rdata_d[`UBCS_ST_TX_RSVD] = tx_src == UBCS_SRC_NONE;
                rdata_d[`UBCS_ST_RX_1X] = rx_src == UBCS_SRC_EXT1;
                rdata_d[`UBCS_ST_TX_1X] = tx_src == UBCS_SRC_EXT1;
                rdata_d[`UBCS_ST_RX_EXT_SEEN] = rx_ext_seen_q;
                rdata_d[`UBCS_ST_TX_EXT_SEEN] = tx_ext_seen_q;
            end
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd ? rdata_d : '0;
        end
    end

    assign rdata = rdata_q;
endmodule // ubcs_top
`default_nettype wire

// ==== verif/ubcs_props.sv ====
// Purpose: port assertions for the bit-rate clock selector
// Assumes: selects change only by register writes
// Notes: events near a write are skipped, a restart drops them
`timescale 1ns/1ps
`default_nettype none
`include "ubcs_regs.svh"
module ubcs_props
    import ubcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`UBCS_ADDR_W-1:0] addr,
    input wire logic [`UBCS_DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [`UBCS_DATA_W-1:0] rdata,
    input wire ubcs_src_in_t src_in,
    input wire logic gpio_three_in,
    input wire logic gpio_four_in,
    input wire ubcs_clk_out_t rx_clk,
    input wire ubcs_clk_out_t tx_clk
);
    logic [5:0] rx_sel_q;
    logic [5:0] tx_sel_q;
    logic [1:0] rx_age_q;
    logic [1:0] tx_age_q;
    logic rx_wr;
    logic tx_wr;
    logic rx_ok;
    logic tx_ok;
    assign rx_wr = wr && addr == `UBCS_RX_SRC_OFS;
    assign tx_wr = wr && addr == `UBCS_TX_SRC_OFS;
    assign rx_ok = rx_age_q == 2'h3 && !rx_wr;
    assign tx_ok = tx_age_q == 2'h3 && !tx_wr;
    always_ff @(posedge clk) begin
        if (rst || rx_wr) begin
            rx_sel_q <= rst ? `UBCS_SRC_RESET : wdata[5:0];
            rx_age_q <= 2'h0;
        end else if (rx_age_q != 2'h3) begin
            rx_age_q <= rx_age_q + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || tx_wr) begin
            tx_sel_q <= rst ? `UBCS_SRC_RESET : wdata[5:0];
            tx_age_q <= 2'h0;
        end else if (tx_age_q != 2'h3) begin
            tx_age_q <= tx_age_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside a read");
    property p_rd_rx; rd && addr == `UBCS_RX_SRC_OFS |=> rdata == {2'h0, $past(rx_sel_q)}; endproperty
    a_rd_rx: assert property (p_rd_rx) else $error("receiver source readback wrong");
    property p_rd_tx; rd && addr == `UBCS_TX_SRC_OFS |=> rdata == {2'h0, $past(tx_sel_q)}; endproperty
    a_rd_tx: assert property (p_rd_tx) else $error("transmitter source readback wrong");
    property p_rd_hole; rd && addr[7:2] != 6'h0C |=> rdata == 8'h00; endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    property p_rx_rsvd; rx_ok && rx_sel_q[5:4] == 2'h3 && rx_sel_q != `UBCS_CODE_PGEN1
        |-> !rx_clk.active && !rx_clk.tick16 && !rx_clk.bit_tick; endproperty
    a_rx_rsvd: assert property (p_rx_rsvd) else $error("reserved code still active");
    property p_rx_tmr; rx_ok && rx_sel_q == `UBCS_CODE_TIMER0 |=> rx_clk.tick16 == $past(src_in.timer0_tick);
    endproperty
    a_rx_tmr: assert property (p_rx_tmr) else $error("timer zero tick not passed");
    property p_tx_pg1; tx_ok && tx_sel_q == `UBCS_CODE_PGEN1 |=> tx_clk.tick16 == $past(src_in.pgen1_tick);
    endproperty
    a_tx_pg1: assert property (p_tx_pg1) else $error("generator one tick not passed");
    property p_rx_e16; rx_ok && rx_sel_q == `UBCS_CODE_EXT16
        |=> rx_clk.tick16 == ($past(gpio_four_in) && !$past(gpio_four_in, 2)); endproperty
    a_rx_e16: assert property (p_rx_e16) else $error("receiver pin clock not passed");
    property p_tx_e1; tx_ok && tx_sel_q == `UBCS_CODE_EXT1 |=> tx_clk.mode_1x && !tx_clk.tick16
        && tx_clk.bit_tick == ($past(gpio_three_in) && !$past(gpio_three_in, 2)); endproperty
    a_tx_e1: assert property (p_tx_e1) else $error("transmitter 1x pin clock wrong");
    property p_pair; rx_ok && rx_clk.bit_tick && !rx_clk.mode_1x |-> rx_clk.tick16; endproperty
    a_pair: assert property (p_pair) else $error("bit tick without 16x tick");
    c_bit: cover property (tx_clk.bit_tick);
    c_rsvd: cover property (rx_ok && !rx_clk.active);
    c_e1: cover property (tx_clk.mode_1x && tx_clk.bit_tick);
endmodule // ubcs_props
bind ubcs_top ubcs_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_in(src_in), .gpio_three_in(gpio_three_in), .gpio_four_in(gpio_four_in),
    .rx_clk(rx_clk), .tx_clk(tx_clk));
`default_nettype wire

// ==== verif/ubcs_far_end.sv ====
// Purpose: timers, generators and pin clocks feeding the selector
// Assumes: run high only while traffic is wanted
// Notes: pins sit low while stopped; distinct periods catch mixed sources
`timescale 1ns/1ps
`default_nettype none
module ubcs_far_end
    import ubcs_pkg::*;
(
    input wire logic clk,
    input wire logic run,
    output ubcs_src_in_t src_in,
    output logic gpio_three_in,
    output logic gpio_four_in
);
    int n = 0;
    initial begin
        src_in = '0;
        gpio_three_in = 1'b0;
        gpio_four_in = 1'b0;
    end
    always @(posedge clk) begin
        n <= n + 1;
        src_in <= {n % 5 == 0, n % 7 == 0, n % 9 == 0, n % 11 == 0} & {4{run}};
        gpio_three_in <= run && n % 6 < 3;
        gpio_four_in <= run && n % 10 < 5;
    end
endmodule // ubcs_far_end
`default_nettype wire

// ==== verif/ubcs_top_bench.sv ====
// Purpose: self-checking bench for the bit-rate clock selector
// Assumes: far-end model drives timers, generators and pins
// Notes: slow rates check first-tick latency only, to bound run time
`timescale 1ns/1ps
`default_nettype none
`include "ubcs_regs.svh"
module ubcs_top_bench
    import ubcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [31:0] rnd;
    logic [5:0] code;
    ubcs_src_in_t src_in;
    logic gpio_three_in;
    logic gpio_four_in;
    ubcs_clk_out_t rx_clk;
    ubcs_clk_out_t tx_clk;
    int fails = 0;
    int n_checks = 0;
    int seed = 8630;
    int d, lat, per;
    int model_sel[2] = '{`UBCS_SRC_RESET, `UBCS_SRC_RESET};
    int baud10[$] = '{500, 1100, 1345, 2000, 3000, 6000, 12000, 10500, 24000, 48000, 72000, 96000, 384000,
        750, 1500, 4500, 18000, 20000, 144000, 192000, 288000, 576000, 1152000, 2304000, 4608000, 9216000, 312500};
    ubcs_top u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .src_in(src_in), .gpio_three_in(gpio_three_in), .gpio_four_in(gpio_four_in), .rx_clk(rx_clk), .tx_clk(tx_clk));
    ubcs_far_end u_far (.clk(clk), .run(run), .src_in(src_in), .gpio_three_in(gpio_three_in),
        .gpio_four_in(gpio_four_in));
    always #5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a[7:1] == 7'h18) model_sel[a[0]] = v[5:0];
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("readback", rdata, a[7:1] == 7'h18 ? model_sel[a[0]] : 0);
    endtask
    // bounded wait; running out is itself a failure
    task automatic wait_tick(output int n, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tx_clk.tick16 !== 1'b1 && n < lim);
        if (n >= lim) begin
            fails++;
            final_report();
        end
    endtask
    function automatic logic ev(input logic [5:0] c, input logic pin, input logic pin_p);
        case (c)
            `UBCS_CODE_TIMER0: return src_in.timer0_tick;
            `UBCS_CODE_TIMER1: return src_in.timer1_tick;
            `UBCS_CODE_PGEN0: return src_in.pgen0_tick;
            `UBCS_CODE_PGEN1: return src_in.pgen1_tick;
            `UBCS_CODE_EXT16, `UBCS_CODE_EXT1: return pin && !pin_p;
            default: return 1'b0;
        endcase
    endfunction
    task automatic src_win(input logic [5:0] rc, input logic [5:0] tc);
        int er, et, nr, nt, br, bt, ta, tt;
        logic p3, p4;
        wr_reg(`UBCS_RX_SRC_OFS, {2'h0, rc});
        wr_reg(`UBCS_TX_SRC_OFS, {2'h0, tc});
        #1;
        p3 = gpio_three_in;
        p4 = gpio_four_in;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk);
            #1;
            if (k > 0) begin
                nr += rx_clk.tick16;
                nt += tx_clk.tick16;
                br += rx_clk.bit_tick;
                bt += tx_clk.bit_tick;
            end
            ta += tx_clk.bit_tick;
            tt += tx_clk.tick16;
            if (k < 199) begin
                er += ev(rc, gpio_four_in, p4);
                et += ev(tc, gpio_three_in, p3);
            end
            p3 = gpio_three_in;
            p4 = gpio_four_in;
        end
        check("rx ticks", nr, rc == `UBCS_CODE_EXT1 ? 0 : er);
        check("tx ticks", nt, tc == `UBCS_CODE_EXT1 ? 0 : et);
        if (rc == `UBCS_CODE_EXT1) check("rx bits", br, er);
        check("tx bits", tc == `UBCS_CODE_EXT1 ? bt : ta, tc == `UBCS_CODE_EXT1 ? et : tt / 16);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`UBCS_RX_SRC_OFS);
        rd_chk(`UBCS_TX_SRC_OFS);
        wr_reg(`UBCS_RX_SRC_OFS, 8'hFF);
        rd_chk(`UBCS_RX_SRC_OFS);
        rd_chk(`UBCS_TX_SRC_OFS);
        rnd = $random(seed);
        wr_reg(8'h40, rnd[7:0]);
        rd_chk(8'h40);
        foreach (baud10[i]) begin
            code = i < 13 ? 6'(i) : (i < 26 ? 6'(i + 3) : `UBCS_CODE_MIDI);
            d = `UBCS_REF_HZ * 10 / (`UBCS_OVERSAMPLE * baud10[i]);
            rnd = $random(seed);
            wr_reg(`UBCS_TX_SRC_OFS, {rnd[1:0], code});
            wait_tick(lat, d + 8);
            check("first tick", lat >= d + 1 && lat <= d + 3, 1);
            if (d < 2000) begin
                wait_tick(per, d + 8);
                check("tick period", per, d);
            end
            rd_chk(`UBCS_TX_SRC_OFS);
        end
        run <= 1'b1;
        src_win(`UBCS_CODE_TIMER0, `UBCS_CODE_TIMER1);
        src_win(`UBCS_CODE_PGEN0, `UBCS_CODE_PGEN1);
        src_win(`UBCS_CODE_EXT16, `UBCS_CODE_EXT1);
        src_win(`UBCS_CODE_EXT1, `UBCS_CODE_EXT16);
        src_win(6'h35, `UBCS_CODE_TIMER0);
        check("rx active", rx_clk.active, 1'b0);
        @(posedge clk);
        addr <= `UBCS_STATUS_OFS;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("status", rdata[3:0], 4'h1);
        final_report();
    end
endmodule // ubcs_top_bench
`default_nettype wire
